// ---- src/rcpm_pkg.sv ----
// constants shared by the reset, clock and power manager
// assumes a single 200 MHz reference clock that runs from power-on
package rcpm_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ        = 200;
  localparam int POR_TIME_US    = 4000;
  localparam int GLOBAL_TIME_US = 2000;
  localparam int XCHK_TIME_MS   = 100;
  localparam int SLOW_KHZ       = 32;
  localparam int QUARTER_KHZ    = 250;
  localparam int SLOW_DIV_CYC   = CLK_MHZ * 1000 / SLOW_KHZ;
  localparam int QUARTER_DIV    = CLK_MHZ * 1000 / QUARTER_KHZ;
  localparam int XCHK_TICK_CNT  = XCHK_TIME_MS * QUARTER_KHZ;
  localparam int CNT_W          = 20;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] REG_CLKCFG  = 8'h00;
  localparam logic [7:0] REG_GATE    = 8'h04;
  localparam logic [7:0] REG_RSTCFG  = 8'h08;
  localparam logic [7:0] REG_RSTFLAG = 8'h0C;
  localparam logic [7:0] REG_SWRST   = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;

  // clock configuration fields
  localparam int CK_PLL_CRYSTAL_OSCILLATOR = 0;
  localparam int CK_XDIV16   = 1;
  localparam int CK_CRYSTAL_OSCILLATOR_EN  = 2;
  localparam int CK_SYSDIV   = 3;
  localparam int CK_CAN_CRYSTAL_OSCILLATOR = 5;
  localparam int CK_CANXING  = 6;
  localparam int CK_WDT_D32  = 8;
  localparam int CK_RTC_SEL  = 9;
  localparam int CK_SLOW_EN  = 11;
  localparam logic [11:0] CLKCFG_RST = 12'h808;

  // clock gates: bits 10..12 feed flash, eeprom and sram
  localparam int           GATE_W    = 13;
  localparam logic [12:0]  GATE_RST  = 13'h1FFF;
  localparam logic [12:0]  GATE_SYS  = 13'h1C00;
  localparam logic [12:0]  GATE_DEEP = 13'h0218;

  // reset configuration fields, kept over functional resets
  localparam int          RC_EXT_EN   = 0;
  localparam int          RC_FILT_EN  = 1;
  localparam int          RC_XCHK_EN  = 2;
  localparam int          RC_XINIT_RS = 3;
  localparam int          RC_XFAIL_RS = 4;
  localparam logic [4:0]  RSTCFG_RST  = 5'h01;

  // reset flags, one per source in bits 0..8; bits 9 and 10 record crystal errors
  localparam int          FLG_POR   = 0;
  localparam int          FLG_PD    = 1;
  localparam int          FLG_WDT   = 2;
  localparam int          FLG_SW    = 3;
  localparam int          FLG_LOCK  = 4;
  localparam int          FLG_EXT   = 5;
  localparam int          FLG_ADDR  = 6;
  localparam int          FLG_XINIT = 7;
  localparam int          FLG_XFAIL = 8;
  localparam int          FLG_XERR  = 9;
  localparam int          FLG_XSEEN = 10;
  localparam logic [8:0]  FLAGS_RST = 9'h001;

  localparam logic [31:0] FLASH_LAST = 32'h0001_7FFF;

  // ****************************************************************
  // states
  // ****************************************************************
  typedef enum logic [1:0] {
    SEQ_WAIT = 2'b00,
    SEQ_POR  = 2'b01,
    SEQ_GLOB = 2'b10,
    SEQ_RUN  = 2'b11
  } rcpm_seq_t;

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_SLEEP  = 2'b01,
    PM_DEEP   = 2'b10
  } rcpm_pm_t;

endpackage

// ---- src/rcpm_rst_sync.sv ----
// reset synchroniser: asserts at once, releases two edges later
// assumes the clock keeps running while the reset is held
`timescale 1ns/10ps
module rcpm_rst_sync (
  input  wire logic clk_i,
  input  wire logic async_rst_b_i,
  output logic      rst_b_o
);
  typedef struct packed {
    logic meta;
    logic hold;
  } rcpm_sync_t;

  rcpm_sync_t st;
  rcpm_sync_t next_st;

  always_comb begin
    next_st.meta = 1'b1;
    next_st.hold = st.meta;
  end

  always_ff @(posedge clk_i or negedge async_rst_b_i) begin
    if (!async_rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rst_b_o = st.hold;
endmodule // rcpm_rst_sync

// ---- src/rcpm_top.sv ----
// reset sequencing, clock selection and gating, sleep modes
// assumes all inputs are synchronous to ref_clk_i, which always runs
`timescale 1ns/10ps
module rcpm_top
  import rcpm_pkg::*;
#(
  parameter int unsigned POR_CYCLES  = POR_TIME_US * CLK_MHZ,
  parameter int unsigned GLOB_CYCLES = GLOBAL_TIME_US * CLK_MHZ,
  parameter int unsigned SLOW_DIV    = SLOW_DIV_CYC,
  parameter int unsigned XCHK_TICKS  = XCHK_TICK_CNT
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        supply_ok_i,
  input  wire logic        pd_reset_i,
  input  wire logic        wdt_overflow_i,
  input  wire logic        processor_indication_a_i,
  input  wire logic        ext_reset_b_i,
  input  wire logic        fetch_valid_i,
  input  wire logic [31:0] fetch_addr_i,
  input  wire logic        crystal_oscillator_ok_i,
  input  wire logic        crystal_oscillator_fail_i,
  input  wire logic        crystal_oscillator_tick_i,
  input  wire logic        wfi_i,
  input  wire logic        deep_sleep_sel_i,
  input  wire logic        wake_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             por_rst_b_o,
  output logic             sys_rst_b_o,
  output logic             cpu_clk_en_o,
  output logic             osc_en_o,
  output logic             crystal_oscillator_enable_o,
  output logic             pll_ref_crystal_oscillator_o,
  output logic             crystal_oscillator_div16_o,
  output logic [1:0]       system_clock_divider_select_o,
  output logic             can_clk_crystal_oscillator_o,
  output logic [1:0]       can_clock_crossing_config_o,
  output logic [12:0]      periph_clk_en_o,
  output logic             slow_rc_enable_o,
  output logic             wdt_tick_o,
  output logic             rtc_tick_o,
  output logic [1:0]       power_mode_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    rcpm_seq_t          seq;
    logic [CNT_W-1:0]   cnt;
    logic               por_rst_b;
    logic               func_rst_b;
    rcpm_pm_t           pm;
    logic               cpu_en;
    logic               osc_en;
    logic [GATE_W-1:0]  pclk;
    logic [11:0]        clkcfg;
    logic [GATE_W-1:0]  gate;
    logic [4:0]         rstcfg;
    logic [8:0]         flags;
    logic               xinit_err;
    logic               xfail_seen;
    logic [12:0]        slow_cnt;
    logic               slow_tick;
    logic [9:0]         q_cnt;
    logic               q_tick;
    logic [4:0]         s32_cnt;
    logic [4:0]         x32_cnt;
    logic               wdt_tick;
    logic               rtc_tick;
    logic               flt_low;
    logic               xchk_busy;
    logic [14:0]        xchk_cnt;
    logic               xen_d;
    logic [31:0]        rdata;
  } rcpm_st_t;

  localparam rcpm_st_t ST_RST = '{
    seq:    SEQ_WAIT,
    pm:     PM_ACTIVE,
    cpu_en: 1'b1,
    osc_en: 1'b1,
    pclk:   GATE_RST,
    clkcfg: CLKCFG_RST,
    gate:   GATE_RST,
    rstcfg: RSTCFG_RST,
    flags:  FLAGS_RST,
    default: '0
  };

  rcpm_st_t   st;
  rcpm_st_t   next_st;
  logic [8:0] src;
  logic       ext_req;
  logic       xinit_fail;
  logic       run;
  logic       sw_wr;
  logic [10:0] clr;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic wrap32(input logic [4:0] c);
    return &c;
  endfunction

  function automatic logic [31:0] reg_read(input rcpm_st_t s,
                                           input logic [7:0] a);
    logic [31:0] d;
    d = '0;
    unique case (a)
      REG_CLKCFG:  d[11:0] = s.clkcfg;
      REG_GATE:    d[GATE_W-1:0] = s.gate;
      REG_RSTCFG:  d[4:0] = s.rstcfg;
      REG_RSTFLAG: d[10:0] = {s.xfail_seen, s.xinit_err, s.flags};
      REG_STATUS:  d[3:0] = {s.seq, s.pm};
      default:     d = '0;
    endcase
    return d;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    run     = (st.seq == SEQ_RUN);
    sw_wr   = run && wr_i && (addr_i == REG_SWRST);
    clr     = (run && wr_i && addr_i == REG_RSTFLAG) ? wdata_i[10:0]
                                                     : '0;

    // slow and quarter-MHz ticks from the always-running clock
    next_st.slow_tick = 1'b0;
    if (st.slow_cnt == 13'(SLOW_DIV - 1)) begin
      next_st.slow_cnt  = '0;
      next_st.slow_tick = st.clkcfg[CK_SLOW_EN];
    end else begin
      next_st.slow_cnt = st.slow_cnt + 13'h1;
    end
    next_st.q_tick = (st.q_cnt == 10'(QUARTER_DIV - 1));
    next_st.q_cnt  = next_st.q_tick ? '0 : st.q_cnt + 10'h1;

    // watchdog and RTC count enables
    if (st.slow_tick) begin
      next_st.s32_cnt = st.s32_cnt + 5'h1;
    end
    if (crystal_oscillator_tick_i) begin
      next_st.x32_cnt = st.x32_cnt + 5'h1;
    end
    next_st.wdt_tick = st.clkcfg[CK_WDT_D32]
                     ? st.slow_tick && wrap32(st.s32_cnt)
                     : st.slow_tick;
    unique case (st.clkcfg[CK_RTC_SEL+:2])
      2'b00:   next_st.rtc_tick = st.slow_tick;
      2'b01:   next_st.rtc_tick = st.slow_tick && wrap32(st.s32_cnt);
      2'b10:   next_st.rtc_tick = crystal_oscillator_tick_i && wrap32(st.x32_cnt);
      default: next_st.rtc_tick = 1'b0;
    endcase

    // external pin: a low must be seen on two slow ticks in a row
    if (st.slow_tick) begin
      next_st.flt_low = !ext_reset_b_i;
    end
    if (!st.rstcfg[RC_EXT_EN]) begin
      ext_req = 1'b0;
    end else if (st.rstcfg[RC_FILT_EN]) begin
      ext_req = st.clkcfg[CK_SLOW_EN] && st.slow_tick
              && !ext_reset_b_i && st.flt_low;
    end else begin
      ext_req = !ext_reset_b_i;
    end

    // crystal start-up check, armed when software enables the crystal
    next_st.xen_d = st.clkcfg[CK_CRYSTAL_OSCILLATOR_EN];
    xinit_fail    = 1'b0;
    if (!st.clkcfg[CK_CRYSTAL_OSCILLATOR_EN]) begin
      next_st.xchk_busy = 1'b0;
    end else if (!st.xen_d && st.rstcfg[RC_XCHK_EN]) begin
      next_st.xchk_busy = 1'b1;
      next_st.xchk_cnt  = '0;
    end else if (st.xchk_busy && st.q_tick) begin
      next_st.xchk_cnt = st.xchk_cnt + 15'h1;
      if (st.xchk_cnt == 15'(XCHK_TICKS - 1)) begin
        next_st.xchk_busy = 1'b0;
        xinit_fail        = !crystal_oscillator_ok_i;
      end
    end
    next_st.xinit_err  = (st.xinit_err & !clr[FLG_XERR]) | xinit_fail;
    next_st.xfail_seen = (st.xfail_seen & !clr[FLG_XSEEN])
                       | (crystal_oscillator_fail_i & st.clkcfg[CK_CRYSTAL_OSCILLATOR_EN]);

    // functional reset sources
    src            = '0;
    src[FLG_PD]    = pd_reset_i;
    src[FLG_WDT]   = wdt_overflow_i;
    src[FLG_SW]    = sw_wr;
    src[FLG_LOCK]  = processor_indication_a_i;
    src[FLG_EXT]   = ext_req;
    src[FLG_ADDR]  = fetch_valid_i && (fetch_addr_i > FLASH_LAST);
    src[FLG_XINIT] = xinit_fail && st.rstcfg[RC_XINIT_RS];
    src[FLG_XFAIL] = crystal_oscillator_fail_i && st.clkcfg[CK_CRYSTAL_OSCILLATOR_EN]
                   && st.rstcfg[RC_XFAIL_RS];

    // register writes
    if (run && wr_i) begin
      unique case (addr_i)
        REG_CLKCFG: next_st.clkcfg = wdata_i[11:0];
        REG_GATE:   next_st.gate = wdata_i[GATE_W-1:0];
        REG_RSTCFG: next_st.rstcfg = wdata_i[4:0];
        default:    next_st.rstcfg = st.rstcfg;
      endcase
    end
    next_st.flags = st.flags & ~clr[8:0];

    // reset sequence, all lengths counted on ref_clk_i
    unique case (st.seq)
      SEQ_WAIT: begin
        next_st.cnt = '0;
        if (supply_ok_i) begin
          next_st.seq = SEQ_POR;
        end
      end
      SEQ_POR: begin
        next_st.cnt = st.cnt + 20'h1;
        if (!supply_ok_i) begin
          next_st.seq = SEQ_WAIT;
        end else if (st.cnt == CNT_W'(POR_CYCLES - 1)) begin
          next_st.seq = SEQ_GLOB;
          next_st.cnt = '0;
        end
      end
      SEQ_GLOB: begin
        next_st.cnt = st.cnt + 20'h1;
        if (st.cnt == CNT_W'(GLOB_CYCLES - 1)) begin
          next_st.seq = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (|src) begin
          next_st.seq   = SEQ_GLOB;
          next_st.cnt   = '0;
          next_st.flags = src;
        end
      end
    endcase

    // sleep modes
    unique case (st.pm)
      PM_ACTIVE: begin
        if (run && wfi_i) begin
          next_st.pm = deep_sleep_sel_i ? PM_DEEP : PM_SLEEP;
        end
      end
      PM_SLEEP, PM_DEEP: begin
        if (wake_i) begin
          next_st.pm = PM_ACTIVE;
        end
      end
      default: next_st.pm = PM_ACTIVE;
    endcase

    // functional reset restores clock configuration, gates and power mode; reset configuration and error bits are kept
    if (next_st.seq != SEQ_RUN) begin
      next_st.clkcfg    = CLKCFG_RST;
      next_st.gate      = GATE_RST;
      next_st.pm        = PM_ACTIVE;
      next_st.xchk_busy = 1'b0;
    end
    next_st.por_rst_b  = (next_st.seq == SEQ_GLOB)
                       || (next_st.seq == SEQ_RUN);
    next_st.func_rst_b = (next_st.seq == SEQ_RUN);

    // clock enables follow the power mode
    next_st.cpu_en = (next_st.pm == PM_ACTIVE);
    next_st.osc_en = (next_st.pm != PM_DEEP);
    unique case (next_st.pm)
      PM_SLEEP: next_st.pclk = next_st.gate & ~GATE_SYS;
      PM_DEEP:  next_st.pclk = next_st.gate & GATE_DEEP;
      default:  next_st.pclk = next_st.gate;
    endcase

    next_st.rdata = rd_i ? reg_read(st, addr_i) : '0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // the system reset stays low until the sequencer reaches run
  rcpm_rst_sync u_sync (
    .clk_i         (ref_clk_i),
    .async_rst_b_i (rst_b_i & st.func_rst_b),
    .rst_b_o       (sys_rst_b_o)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata_o                       = st.rdata;
  assign por_rst_b_o                   = st.por_rst_b;
  assign cpu_clk_en_o                  = st.cpu_en;
  assign osc_en_o                      = st.osc_en;
  assign crystal_oscillator_enable_o                 = st.clkcfg[CK_CRYSTAL_OSCILLATOR_EN];
  assign pll_ref_crystal_oscillator_o                = st.clkcfg[CK_PLL_CRYSTAL_OSCILLATOR];
  assign crystal_oscillator_div16_o                  = st.clkcfg[CK_XDIV16];
  assign system_clock_divider_select_o = st.clkcfg[CK_SYSDIV+:2];
  assign can_clk_crystal_oscillator_o                = st.clkcfg[CK_CAN_CRYSTAL_OSCILLATOR];
  assign can_clock_crossing_config_o   = st.clkcfg[CK_CANXING+:2];
  assign periph_clk_en_o               = st.pclk;
  assign slow_rc_enable_o              = st.clkcfg[CK_SLOW_EN];
  assign wdt_tick_o                    = st.wdt_tick;
  assign rtc_tick_o                    = st.rtc_tick;
  assign power_mode_o                  = st.pm;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_por_length: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (st.seq == SEQ_GLOB && $past(st.seq) == SEQ_POR)
      |-> $past(st.cnt) == CNT_W'(POR_CYCLES - 1))
    else $error("power-on phase length wrong");

  a_glob_length: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (st.seq == SEQ_RUN && $past(st.seq) == SEQ_GLOB)
      |-> $past(st.cnt) == CNT_W'(GLOB_CYCLES - 1))
    else $error("global reset length wrong");

  a_src_to_glob: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (run && |src) |=> (st.seq == SEQ_GLOB && !st.func_rst_b
                       && st.cnt == '0))
    else $error("reset source did not start global reset");

  a_flag_cause: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (run && |src) |=> st.flags == $past(src))
    else $error("reset flags do not show the cause");

  a_wdt_reset: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (run && wdt_overflow_i) |=> st.flags[FLG_WDT] ##1 !sys_rst_b_o)
    else $error("watchdog overflow did not reset");

  a_sw_reset: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (run && wr_i && addr_i == REG_SWRST) |=> st.flags[FLG_SW])
    else $error("software reset write ignored");

  a_processor_indication_a_rst: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (run && processor_indication_a_i) |=> st.flags[FLG_LOCK])
    else $error("lock-up did not reset");

  a_addr_ovf: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (run && fetch_valid_i && fetch_addr_i > FLASH_LAST)
      |=> st.flags[FLG_ADDR])
    else $error("fetch overflow did not reset");

  a_filter_off: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (st.rstcfg[RC_FILT_EN] && !st.clkcfg[CK_SLOW_EN]) |-> !ext_req)
    else $error("pin passed with slow clock off");

  a_sync_release: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(sys_rst_b_o) |-> $past(st.func_rst_b, 2) && st.func_rst_b)
    else $error("system reset released out of step");

  a_sleep_entry: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (run && st.pm == PM_ACTIVE && wfi_i && !deep_sleep_sel_i && !(|src))
      |=> (st.pm == PM_SLEEP && !cpu_clk_en_o && osc_en_o))
    else $error("normal sleep entry wrong");

  a_deep_osc_off: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (st.pm == PM_DEEP) |-> (!osc_en_o && (st.pclk & ~GATE_DEEP) == '0))
    else $error("deep sleep left clocks running");

  a_xinit_flag: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    xinit_fail |=> st.xinit_err)
    else $error("crystal start failure not recorded");

endmodule // rcpm_top

// ---- tb/rcpm_cpu_model.sv ----
// processor-side partner: executes wait-for-interrupt when told to
// assumes the bench pulses sleep_req_i for one cycle after a clock edge
`timescale 1ns/10ps
module rcpm_cpu_model (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic cpu_clk_en_i,
  input  wire logic sleep_req_i,
  input  wire logic deep_i,
  output logic      wfi_o,
  output logic      deep_sel_o
);
  // ****************************************************************
  // sleep request
  // ****************************************************************
  // a processor held in reset or with its clock gated cannot execute it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wfi_o      <= 1'b0;
      deep_sel_o <= 1'b0;
    end else begin
      wfi_o      <= sleep_req_i & cpu_clk_en_i;
      deep_sel_o <= deep_i;
    end
  end
endmodule // rcpm_cpu_model

// ---- tb/reset_clock_power_manager_test.sv ----
// self-checking bench for the reset, clock and power manager
// assumes short reset counts; drives inputs by nba at the rising edge
`timescale 1ns/10ps
module reset_clock_power_manager_test;
  import rcpm_pkg::*;
  localparam int PC = 40;
  localparam int GC = 20;
  localparam int SD = 8;
  localparam int XT = 4;
  logic ref_clk_i = 0, rst_b_i = 0, sup = 0, pd = 0, wdt = 0, lock = 0;
  logic ext_b = 1, fv = 0, req = 0, deep = 0, wake = 0, wr = 0, rd = 0;
  logic xok = 0;
  logic [7:0]  addr = '0;
  logic [31:0] wdata = '0, rdata, d, fa = '0;
  logic        por_b, sys_b, cpu_en, osc_en, wfi, dsel;
  logic [12:0] periph;
  logic [1:0]  pm;
  // clock config outputs packed in register order, slow oscillator enable on top
  wire  [8:0]  cko;
  wire         wtk, rtk;
  int          err_count = 0, num_checks = 0, cyc = 0, n, nw, nr;
  int          fbit [5] = '{FLG_PD, FLG_WDT, FLG_LOCK, FLG_ADDR, FLG_SW};

  always #2.5 ref_clk_i = ~ref_clk_i;

  rcpm_top #(.POR_CYCLES(PC), .GLOB_CYCLES(GC), .SLOW_DIV(SD),
    .XCHK_TICKS(XT)) u_rcpm_top (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .supply_ok_i(sup),
    .pd_reset_i(pd), .wdt_overflow_i(wdt), .processor_indication_a_i(lock),
    .ext_reset_b_i(ext_b), .fetch_valid_i(fv),
    .fetch_addr_i(fa), .crystal_oscillator_ok_i(xok), .crystal_oscillator_fail_i(1'b0),
    .crystal_oscillator_tick_i(1'b0), .wfi_i(wfi), .deep_sleep_sel_i(dsel),
    .wake_i(wake), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .por_rst_b_o(por_b), .sys_rst_b_o(sys_b),
    .cpu_clk_en_o(cpu_en), .osc_en_o(osc_en), .crystal_oscillator_enable_o(cko[2]),
    .pll_ref_crystal_oscillator_o(cko[0]), .crystal_oscillator_div16_o(cko[1]),
    .system_clock_divider_select_o(cko[4:3]),
    .can_clk_crystal_oscillator_o(cko[5]), .can_clock_crossing_config_o(cko[7:6]),
    .periph_clk_en_o(periph), .slow_rc_enable_o(cko[8]), .wdt_tick_o(wtk),
    .rtc_tick_o(rtk), .power_mode_o(pm));

  rcpm_cpu_model u_rcpm_cpu_model (.clk_i(ref_clk_i), .rst_b_i(sys_b),
    .cpu_clk_en_i(cpu_en), .sleep_req_i(req), .deep_i(deep),
    .wfi_o(wfi), .deep_sel_o(dsel));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    addr <= a; rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // waits out the global reset; the count bounds a hang
  task automatic wait_run(output int c);
    c = 0;
    repeat (2) @(posedge ref_clk_i);
    while (sys_b !== 1'b1 && c < 1000) begin
      @(posedge ref_clk_i);
      #1;
      c++;
    end
  endtask

  // counts count-enable pulses over a window of whole tick periods
  task automatic ticks(input int c, output int w, output int r);
    w = 0;
    r = 0;
    repeat (c) begin
      @(posedge ref_clk_i);
      #1;
      w += int'(wtk);
      r += int'(rtk);
    end
  endtask

  task automatic pulse(input int k);
    if (k == 4) wreg(REG_SWRST, 32'h0000_0001);
    else begin
      @(posedge ref_clk_i);
      pd <= (k == 0); wdt <= (k == 1); lock <= (k == 2); fv <= (k == 3);
      @(posedge ref_clk_i);
      {pd, wdt, lock, fv} <= 4'h0;
    end
  endtask

  task automatic pin_low(input int c);
    @(posedge ref_clk_i) ext_b <= 1'b0;
    repeat (c) @(posedge ref_clk_i);
    ext_b <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
  endtask

  task automatic sleep(input logic dp);
    @(posedge ref_clk_i) begin req <= 1'b1; deep <= dp; end
    @(posedge ref_clk_i) req <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    #1 chk(32'(por_b), 32'h0);
    chk(32'(sys_b), 32'h0);
    repeat (3) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i) sup <= 1'b1;
    n = 0;
    while (por_b !== 1'b1 && n < 1000) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk(32'(n >= PC - 2 && n <= PC + 3), 32'h1);
    wait_run(n);
    chk(32'(n >= GC - 2 && n <= GC + 5), 32'h1);
    rreg(REG_CLKCFG, d); chk(d, 32'(CLKCFG_RST));
    chk(32'(cko), 32'({CLKCFG_RST[11], CLKCFG_RST[7:0]}));
    rreg(REG_GATE, d); chk(d, 32'(GATE_RST));
    rreg(REG_RSTFLAG, d); chk(d, 32'(FLAGS_RST));
    rreg(8'h20, d); chk(d, 32'h0000_0000);
    wreg(REG_GATE, 32'h0000_0155);
    rreg(REG_GATE, d); chk(32'(periph), 32'h0000_0155);
    chk(d, 32'h0000_0155);
    wreg(REG_RSTCFG, 32'h0000_0000);
    pin_low(10); chk(32'(sys_b), 32'h1);
    // the last flash word is still a legal fetch
    fa <= FLASH_LAST;
    pulse(3);
    repeat (2) @(posedge ref_clk_i);
    chk(32'(sys_b), 32'h1);
    fa <= FLASH_LAST + 32'h1;
    for (int k = 0; k < 5; k++) begin
      wreg(REG_RSTFLAG, 32'h0000_07FF);
      pulse(k);
      wait_run(n);
      rreg(REG_RSTFLAG, d); chk(d, 32'h1 << fbit[k]);
      rreg(REG_RSTCFG, d); chk(d, 32'h0000_0000);
      chk(32'(periph), 32'(GATE_RST));
    end
    // filter on with the slow oscillator off: the pin must be ignored
    wreg(REG_CLKCFG, 32'h0000_0008);
    wreg(REG_RSTCFG, 32'h0000_0003);
    pin_low(40); chk(32'(sys_b), 32'h1);
    wreg(REG_CLKCFG, 32'h0000_0808);
    wreg(REG_RSTFLAG, 32'h0000_07FF);
    pin_low(4); chk(32'(sys_b), 32'h1);
    pin_low(40);
    wait_run(n);
    rreg(REG_RSTFLAG, d); chk(d, 32'h1 << FLG_EXT);
    // count enables: every slow period, then once in 32 of them
    ticks(8 * SD, nw, nr);
    chk(32'(nw), 32'h8);
    chk(32'(nr), 32'h8);
    wreg(REG_CLKCFG, 32'h0000_0B08);
    ticks(32 * SD, nw, nr);
    chk(32'(nw), 32'h1);
    chk(32'(nr), 32'h1);
    // a dead crystal resets once the start check expires
    wreg(REG_RSTCFG, 32'h0000_000D);
    wreg(REG_CLKCFG, 32'h0000_080C);
    repeat (XT * QUARTER_DIV + 16) @(posedge ref_clk_i);
    wait_run(n);
    rreg(REG_RSTFLAG, d);
    chk(d, 32'h1 << FLG_XINIT | 32'h1 << FLG_XERR);
    // a good crystal passes the check and only then is switched to
    @(posedge ref_clk_i) xok <= 1'b1;
    wreg(REG_RSTFLAG, 32'h0000_07FF);
    wreg(REG_CLKCFG, 32'h0000_080C);
    repeat (XT * QUARTER_DIV + 16) @(posedge ref_clk_i);
    rreg(REG_RSTFLAG, d);
    chk(d, 32'h0000_0000);
    wreg(REG_CLKCFG, 32'h0000_0877);
    rreg(REG_CLKCFG, d);
    chk(d, 32'h0000_0877);
    chk(32'(cko), 32'h0000_0177);
    sleep(1'b0);
    chk(32'(pm), 32'(PM_SLEEP));
    chk(32'(cpu_en), 32'h0);
    chk(32'(periph & GATE_SYS), 32'h0);
    chk(32'(osc_en), 32'h1);
    @(posedge ref_clk_i) wake <= 1'b1;
    @(posedge ref_clk_i) wake <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 chk(32'(pm), 32'(PM_ACTIVE));
    sleep(1'b1);
    chk(32'(pm), 32'(PM_DEEP));
    chk(32'(osc_en), 32'h0);
    chk(32'(periph), 32'(GATE_DEEP));
    tally_and_finish();
  end
endmodule // reset_clock_power_manager_test
